// [design/adc_sequence_trigger_control.sv]
// Trigger detection, phase delay and arbitration for four sample sequencers
//
// Function
// - Phase delay of sixteen even steps between trigger and sequence start.
// - One phase setting for the whole module, shared by all sequencers.
// - Processor trigger starts a sequencer only if its source is processor.
// - Wait-flagged processor trigger held until another module signals; both start.
// - Reference selection holds internal, external high or external low code.
// - Reference selection reads back as programmed; a write of code three is ignored and keeps the old code.
// - Four sequencers, depths eight, four, four and one.
// - Per-sequencer source: processor, comparators, pin, timer, PWM, always.
// - External source comes from a dedicated pin input.
// - Always source captures back to back when nothing higher is active.
// - Two-bit priority per sequencer, zero highest, three lowest.
// - Priorities order sequencers whose triggers are pending together.
// - Disabled sequencer ignores triggers; a run already granted to it still starts and completes.
// - Overflow flag set when a trigger finds unread samples.
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_trigger_control
  import adc_trig_pkg::*;
#(
  parameter int STEP_CYC = adc_trig_pkg::PHASE_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [adc_trig_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] acmp_trig_in,
  input wire logic ext_trig_pin,
  input wire logic timer_trig_in,
  input wire logic [3:0] pwmgen_trig_in,
  input wire logic [adc_trig_pkg::NUM_SEQ-1:0] fifo_empty_in,
  input wire logic conv_done_in,
  input wire logic sync_signal_in,
  output logic sync_signal_out,
  output logic conv_start_out,
  output logic [1:0] conv_seq_out,
  output logic [3:0] conv_steps_out,
  output logic [1:0] ref_sel_out
);
  import adc_trig_pkg::*;

  if (STEP_CYC < 1 || STEP_CYC > 4096) begin : g_chk
    $error("adc_sequence_trigger_control: STEP_CYC out of range");
  end

  typedef enum {st_idle, st_delay, st_run} state_type;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] wmask;
  logic bus_req;
  logic wr_take;
  logic hit_ctrl;
  logic hit_src;
  logic hit_prio;
  logic hit_proc;
  logic hit_stat;
  logic [31:0] rd_mux;

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_take = bus_req & wb_we_i & ack_q;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign hit_ctrl = wb_adr_i == OFS_CTRL;
  assign hit_src = wb_adr_i == OFS_TRIGSRC;
  assign hit_prio = wb_adr_i == OFS_PRIO;
  assign hit_proc = wb_adr_i == OFS_PROCTRIG;
  assign hit_stat = wb_adr_i == OFS_STATUS;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [3:0] en_q;
  logic [3:0] phase_q;
  logic [1:0] ref_q;
  logic [15:0] src_q;
  logic [7:0] prio_q;
  logic [31:0] ctrl_w;
  logic ref_ok;

  assign ctrl_w = ({22'h0, ref_q, phase_q, en_q} & ~wmask) | (wb_dat_i & wmask);
  assign ref_ok = ctrl_w[CTRL_REF_LSB +: 2] != 2'h3;
  assign ref_sel_out = ref_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 4'h0;
      phase_q <= 4'h0;
      ref_q <= ref_sel_internal;
    end else if (wr_take && hit_ctrl) begin
      en_q <= ctrl_w[CTRL_EN_LSB +: 4];
      phase_q <= ctrl_w[CTRL_PHASE_LSB +: 4];
      if (ref_ok) begin
        ref_q <= ctrl_w[CTRL_REF_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_q <= TRIGSRC_RST;
      prio_q <= PRIO_RST;
    end else if (wr_take) begin
      if (hit_src) begin
        src_q <= (src_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      if (hit_prio) begin
        prio_q <= (prio_q & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger inputs
  // ----------------------------------------------------------------
  logic [4:0] pin_rise;
  logic [4:0] int_rise;
  logic sync_rise;
  logic [15:0] ev_vec;

  trig_edge_detect #(.WIDTH(5), .SYNC(1'b1)) u_pin_edges (
    .clk(clk),
    .rst_b(rst_b),
    .level_in({sync_signal_in, ext_trig_pin, acmp_trig_in}),
    .rise_out(pin_rise)
  );

  trig_edge_detect #(.WIDTH(5), .SYNC(1'b0)) u_int_edges (
    .clk(clk),
    .rst_b(rst_b),
    .level_in({pwmgen_trig_in, timer_trig_in}),
    .rise_out(int_rise)
  );

  assign sync_rise = pin_rise[4];
  // Indexed by source code; processor and always are handled apart
  assign ev_vec = {6'h00, int_rise[4:1], int_rise[0], pin_rise[3], pin_rise[2:0], 1'b0};

  // ----------------------------------------------------------------
  // Processor trigger command
  // ----------------------------------------------------------------
  logic pt_wr;
  logic [3:0] pt_mask;
  logic pt_wait;
  logic pt_signal;
  logic sig_q;

  assign pt_wr = wr_take & hit_proc & wb_sel_i[0];
  assign pt_mask = wb_dat_i[3:0];
  assign pt_wait = wb_dat_i[PROC_WAIT_BIT];
  assign pt_signal = wb_dat_i[PROC_SIGNAL_BIT];
  assign sync_signal_out = sig_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_q <= 1'b0;
    end else begin
      sig_q <= pt_wr & pt_signal & ~pt_wait;
    end
  end

  // ----------------------------------------------------------------
  // Per-sequencer pending, held and overflow state
  // ----------------------------------------------------------------
  state_type state_q;
  logic [1:0] act_q;
  logic [3:0] pend_q;
  logic [3:0] held_q;
  logic [3:0] ovf_q;
  logic [3:0] req;
  logic [3:0] hw_ev;
  logic [3:0] trig_any;
  logic ovf_clr_wr;
  logic grant_valid;
  logic [1:0] grant_id;

  assign ovf_clr_wr = wr_take & hit_stat & wb_sel_i[0];

  for (genvar s = 0; s < NUM_SEQ; s++) begin : g_seq
    logic [3:0] src;
    logic is_proc;
    logic is_always;
    logic proc_go;
    logic proc_hold;
    logic release_go;
    logic started;

    assign src = src_q[s*SRC_W +: SRC_W];
    assign is_proc = src == trig_src_processor;
    assign is_always = src == trig_src_always;
    assign hw_ev[s] = en_q[s] & ev_vec[src];
    assign proc_go = en_q[s] & is_proc & pt_wr & pt_mask[s] & ~pt_wait;
    assign proc_hold = en_q[s] & is_proc & pt_wr & pt_mask[s] & pt_wait;
    assign release_go = en_q[s] & held_q[s] & sync_rise;
    assign trig_any[s] = hw_ev[s] | proc_go | release_go;
    assign req[s] = en_q[s] & (pend_q[s] | is_always);
    assign started = conv_start_out & (act_q == 2'(s));

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pend_q[s] <= 1'b0;
        held_q[s] <= 1'b0;
        ovf_q[s] <= 1'b0;
      end else begin
        // New event wins over the clear of the run that starts now
        pend_q[s] <= en_q[s] & (trig_any[s] | (pend_q[s] & ~started));
        held_q[s] <= en_q[s] & (proc_hold | (held_q[s] & ~sync_rise));
        ovf_q[s] <= (trig_any[s] & ~fifo_empty_in[s])
          | (ovf_q[s] & ~(ovf_clr_wr & wb_dat_i[STAT_OVF_LSB + s]));
      end
    end

    a_proc_src_only:
    assert property (@(posedge clk) disable iff (!rst_b)
      (pt_wr && pt_mask[s] && !is_proc && !hw_ev[s] && !release_go && !pend_q[s])
      |=> !pend_q[s])
      else $error("processor trigger took a non-processor sequencer");
    a_held_release:
    assert property (@(posedge clk) disable iff (!rst_b)
      (held_q[s] && en_q[s] && sync_rise) |=> (pend_q[s] && !held_q[s]))
      else $error("held trigger not released by signal");
    a_disabled_quiet:
    assert property (@(posedge clk) disable iff (!rst_b)
      !en_q[s] |=> (!pend_q[s] && !held_q[s]))
      else $error("disabled sequencer kept a trigger");
    a_overflow_set:
    assert property (@(posedge clk) disable iff (!rst_b)
      (trig_any[s] && !fifo_empty_in[s]) |=> ovf_q[s])
      else $error("overflow flag missed");
    a_pending_kept:
    assert property (@(posedge clk) disable iff (!rst_b)
      (pend_q[s] && en_q[s] && !started) |=> pend_q[s])
      else $error("pending trigger lost");
    a_edge_once:
    assert property (@(posedge clk) disable iff (!rst_b)
      hw_ev[s] |=> !hw_ev[s])
      else $error("edge event seen twice");
    a_always_repeat:
    assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == st_idle && en_q[s] && is_always) |=> state_q == st_delay)
      else $error("always source did not restart");
    a_priority_order:
    assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == st_idle && grant_valid && req[s])
      |-> prio_q[s*PRIO_W +: PRIO_W] >= prio_q[grant_id*PRIO_W +: PRIO_W])
      else $error("lower priority sequencer granted");
  end

  seq_priority_arbiter #(.NUM(NUM_SEQ), .PRIO_W(PRIO_W)) u_arb (
    .req(req),
    .prio(prio_q),
    .grant_valid(grant_valid),
    .grant_id(grant_id)
  );

  // ----------------------------------------------------------------
  // Phase delay and run control
  // ----------------------------------------------------------------
  logic [15:0] cnt_q;
  logic [3:0] steps_q;
  logic [15:0] delay_load;

  // Phase steps are a sixteenth of the sample period each
  assign delay_load = 16'(phase_q) * 16'(STEP_CYC);
  assign conv_start_out = (state_q == st_delay) && (cnt_q == 16'h0000);
  assign conv_seq_out = act_q;
  assign conv_steps_out = steps_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= st_idle;
      cnt_q <= 16'h0000;
      act_q <= 2'h0;
      steps_q <= 4'h0;
    end else begin
      case (state_q)
        st_idle: begin
          if (grant_valid) begin
            state_q <= st_delay;
            act_q <= grant_id;
            steps_q <= SEQ_DEPTH[grant_id*4 +: 4];
            cnt_q <= delay_load;
          end
        end
        st_delay: begin
          if (cnt_q == 16'h0000) begin
            state_q <= st_run;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        st_run: begin
          if (conv_done_in) begin
            state_q <= st_idle;
          end
        end
        default: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux and bus answer
  // ----------------------------------------------------------------
  logic [31:0] stat_w;

  assign stat_w = {17'h00000, act_q, state_q != st_idle, held_q, ovf_q, pend_q};
  assign rd_mux = hit_ctrl ? {22'h0, ref_q, phase_q, en_q}
    : hit_src ? {16'h0000, src_q}
    : hit_prio ? {24'h0, prio_q}
    : hit_proc ? {28'h0, held_q}
    : hit_stat ? stat_w : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req && !ack_q) begin
        dat_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks on delay, reference, depth and bus answer
  // ----------------------------------------------------------------
  logic [15:0] dly_seen_q;
  logic [15:0] dly_exp_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dly_seen_q <= 16'h0000;
      dly_exp_q <= 16'h0000;
    end else if (state_q == st_idle) begin
      dly_seen_q <= 16'h0000;
      dly_exp_q <= delay_load;
    end else if (state_q == st_delay) begin
      dly_seen_q <= dly_seen_q + 16'h0001;
    end
  end

  a_phase_delay_len:
  assert property (@(posedge clk) disable iff (!rst_b)
    conv_start_out |-> dly_seen_q == dly_exp_q)
    else $error("phase delay length wrong");
  a_phase_common:
  assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == st_idle && grant_valid) |=> cnt_q == 16'($past(phase_q)) * 16'(STEP_CYC))
    else $error("phase delay not module wide");
  a_ref_readback:
  assert property (@(posedge clk) disable iff (!rst_b)
    (wr_take && hit_ctrl && wb_sel_i[1] && ref_ok) |=> ref_q == $past(wb_dat_i[9:8]))
    else $error("reference selection not kept");
  a_depth_match:
  assert property (@(posedge clk) disable iff (!rst_b)
    conv_start_out |-> conv_steps_out == ((act_q == 2'h0) ? 4'h8 : (act_q == 2'h3) ? 4'h1 : 4'h4))
    else $error("sequencer depth wrong");
  a_ack_one_cycle:
  assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus answer held too long");

endmodule : adc_sequence_trigger_control
`default_nettype wire

// [design/seq_priority_arbiter.sv]
// Picks the requesting sequencer with the numerically lowest priority
`timescale 1ns/1ps
`default_nettype none
module seq_priority_arbiter #(
  parameter int NUM = 4,
  parameter int PRIO_W = 2
) (
  input wire logic [NUM-1:0] req,
  input wire logic [NUM*PRIO_W-1:0] prio,
  output logic grant_valid,
  output logic [$clog2(NUM)-1:0] grant_id
);
  if (NUM < 2) begin : g_chk
    $error("seq_priority_arbiter: NUM must be at least 2");
  end

  // ----------------------------------------------------------------
  // Search
  // ----------------------------------------------------------------
  // Equal priorities fall back to the lower index; software keeps them distinct
  always_comb begin
    logic [PRIO_W-1:0] best;
    best = '1;
    grant_valid = 1'b0;
    grant_id = '0;
    for (int s = 0; s < NUM; s++) begin
      if (req[s] && (!grant_valid || prio[s*PRIO_W +: PRIO_W] < best)) begin
        grant_valid = 1'b1;
        best = prio[s*PRIO_W +: PRIO_W];
        grant_id = s[$clog2(NUM)-1:0];
      end
    end
  end
endmodule : seq_priority_arbiter
`default_nettype wire

// [design/trig_edge_detect.sv]
// Rising edge detector for trigger inputs, optional two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module trig_edge_detect #(
  parameter int WIDTH = 5,
  parameter bit SYNC = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise_out
);
  if (WIDTH < 1) begin : g_chk
    $error("trig_edge_detect: WIDTH must be at least 1");
  end

  // ----------------------------------------------------------------
  // Per input: optional synchroniser, then edge
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic lvl;
    logic prev_q;
    if (SYNC) begin : g_sync
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= level_in[i];
          sync_q <= meta_q;
        end
      end
      assign lvl = sync_q;
    end else begin : g_direct
      assign lvl = level_in[i];
    end
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        prev_q <= 1'b0;
      end else begin
        prev_q <= lvl;
      end
    end
    assign rise_out[i] = lvl & ~prev_q;
  end
endmodule : trig_edge_detect
`default_nettype wire

// [pkg/adc_trig_pkg.sv]
// Constants and types shared by the converter trigger front end
package adc_trig_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int SAMPLE_PERIOD_NS = 3200;
  localparam int PHASE_SETTINGS = 16;
  localparam int PHASE_STEP_NS = SAMPLE_PERIOD_NS / PHASE_SETTINGS;
  localparam int PHASE_STEP_RAW = PHASE_STEP_NS * (CLK_FREQ_HZ / 1_000_000) / 1000;
  localparam int PHASE_STEP_CYC = (PHASE_STEP_RAW < 1) ? 1 : PHASE_STEP_RAW;

  // ----------------------------------------------------------------
  // Sequencers
  // ----------------------------------------------------------------
  localparam int NUM_SEQ = 4;
  localparam int PRIO_W = 2;
  localparam int SRC_W = 4;
  // Depth nibble per sequencer, sequencer 0 in the low nibble
  localparam logic [15:0] SEQ_DEPTH = 16'h1448;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIGSRC = 8'h04;
  localparam logic [7:0] OFS_PRIO = 8'h08;
  localparam logic [7:0] OFS_PROCTRIG = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_PHASE_LSB = 4;
  localparam int CTRL_REF_LSB = 8;
  localparam int PROC_WAIT_BIT = 4;
  localparam int PROC_SIGNAL_BIT = 5;
  localparam int STAT_PEND_LSB = 0;
  localparam int STAT_OVF_LSB = 4;
  localparam int STAT_HELD_LSB = 8;
  localparam int STAT_BUSY_BIT = 12;
  localparam int STAT_ACT_LSB = 13;
  localparam logic [15:0] TRIGSRC_RST = 16'h0000;
  localparam logic [7:0] PRIO_RST = 8'hE4;

  typedef enum logic [3:0] {
    trig_src_processor = 4'h0,
    trig_src_acmp_a = 4'h1,
    trig_src_acmp_b = 4'h2,
    trig_src_acmp_c = 4'h3,
    trig_src_external = 4'h4,
    trig_src_timer = 4'h5,
    trig_src_pwmgen_a = 4'h6,
    trig_src_pwmgen_b = 4'h7,
    trig_src_pwmgen_c = 4'h8,
    trig_src_pwmgen_d = 4'h9,
    trig_src_always = 4'hF
  } trig_src_type;

  typedef enum logic [1:0] {
    ref_sel_internal = 2'h0,
    ref_sel_external_high = 2'h1,
    ref_sel_external_low = 2'h2
  } ref_sel_type;

endpackage : adc_trig_pkg

// [testbench/adc_sequence_trigger_control_tb_top.sv]
// Self-checking bench for the converter trigger front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module adc_sequence_trigger_control_tb_top;
  import adc_trig_pkg::*;
  // Two cycles a phase step keeps the longest delay short but still visible
  localparam int STEP = 2;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [2:0] acmp_trig_in = 3'h0;
  logic ext_trig_pin = 1'b0;
  logic timer_trig_in = 1'b0;
  logic [3:0] pwmgen_trig_in = 4'h0;
  logic [3:0] fifo_empty_in;
  logic conv_done_in;
  logic sync_signal_in = 1'b0;
  logic sync_signal_out;
  logic conv_start_out;
  logic [1:0] conv_seq_out;
  logic [3:0] conv_steps_out;
  logic [1:0] ref_sel_out;
  logic [7:0] run_len = 8'h06;
  logic drain = 1'b0;
  logic [31:0] q;
  int bad_count = 0;
  int comparisons = 0;
  int sync_seen = 0;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (sync_signal_out === 1'b1) begin
      sync_seen++;
    end
  end

  adc_sequence_trigger_control #(.STEP_CYC(STEP)) dut (.clk(clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .acmp_trig_in(acmp_trig_in), .ext_trig_pin(ext_trig_pin), .timer_trig_in(timer_trig_in),
    .pwmgen_trig_in(pwmgen_trig_in), .fifo_empty_in(fifo_empty_in),
    .conv_done_in(conv_done_in), .sync_signal_in(sync_signal_in),
    .sync_signal_out(sync_signal_out), .conv_start_out(conv_start_out),
    .conv_seq_out(conv_seq_out), .conv_steps_out(conv_steps_out), .ref_sel_out(ref_sel_out));

  conv_model far (.clk(clk), .rst_b(rst_b), .conv_start_out(conv_start_out),
    .conv_seq_out(conv_seq_out), .run_len(run_len), .drain(drain),
    .conv_done_in(conv_done_in), .fifo_empty_in(fifo_empty_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'hF;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
    @(posedge clk);
    if (n >= 20) begin
      bad_count++;
      end_sim();
    end
  endtask : wb

  task automatic wait_start(output int n);
    n = 0;
    while (conv_start_out !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      end_sim();
    end
  endtask : wait_start

  // Waits out the run, then the idle cycle before the next grant
  task automatic run_chk(input logic [1:0] s, input logic [3:0] st);
    int n;
    wait_start(n);
    `CHK({conv_seq_out, conv_steps_out}, {s, st})
    n = 0;
    while (conv_done_in !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      end_sim();
    end
    repeat (2) @(posedge clk);
  endtask : run_chk

  task automatic no_start(input int n);
    repeat (n) begin
      @(posedge clk);
      `CHK(conv_start_out, 1'b0)
    end
  endtask : no_start

  task automatic fire(input logic [3:0] c, input logic v);
    case (c)
      4'h1, 4'h2, 4'h3: acmp_trig_in[c - 4'h1] <= v;
      4'h4: ext_trig_pin <= v;
      4'h5: timer_trig_in <= v;
      default: pwmgen_trig_in[c - 4'h6] <= v;
    endcase
  endtask : fire

  function automatic logic [31:0] ctl(logic [3:0] en, logic [3:0] ph, logic [1:0] rf);
    return {22'h0, rf, ph, en};
  endfunction : ctl

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    `CHK({wb_ack_o, sync_signal_out, conv_start_out, ref_sel_out, conv_seq_out}, 7'h00)
    wb(1'b0, OFS_PRIO, 32'h0);
    `CHK(q, {24'h0, PRIO_RST})
    wb(1'b0, OFS_TRIGSRC, 32'h0);
    `CHK(q, {16'h0, TRIGSRC_RST})
    wb(1'b0, 8'h1C, 32'h0);
    `CHK(q, 32'h0)
    $display("test reset done");
  endtask : t_reset

  task automatic t_ref;
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, OFS_CTRL, ctl(4'h0, 4'h0, r[1:0]));
      wb(1'b0, OFS_CTRL, 32'h0);
      `CHK(q[9:8], (r == 3) ? 2'h2 : r[1:0])
      `CHK(ref_sel_out, (r == 3) ? 2'h2 : r[1:0])
    end
    $display("test reference done");
  endtask : t_ref

  // Each edge source (codes 1 to 9) held high past its run: one event, one run
  task automatic t_sources;
    wb(1'b1, OFS_CTRL, ctl(4'h1, 4'h0, 2'h0));
    for (int c = 1; c < 10; c++) begin
      wb(1'b1, OFS_TRIGSRC, c);
      fire(c[3:0], 1'b1);
      run_chk(2'h0, 4'h8);
      no_start(12);
      fire(c[3:0], 1'b0);
    end
    $display("test sources done");
  endtask : t_sources

  task automatic t_phase;
    int n;
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, OFS_CTRL, ctl(4'h6, 4'(i * 7), 2'h0));
      wb(1'b1, OFS_TRIGSRC, 32'h0550);
      fire(4'h5, 1'b1);
      wait_start(n);
      `CHK(n, 3 + i * 7 * STEP)
      run_chk(2'h1, 4'h4);
      wait_start(n);
      `CHK(n, i * 7 * STEP)
      run_chk(2'h2, 4'h4);
      fire(4'h5, 1'b0);
    end
    $display("test phase done");
  endtask : t_phase

  task automatic t_prio;
    wb(1'b1, OFS_CTRL, ctl(4'h0, 4'h0, 2'h0));
    wb(1'b1, OFS_TRIGSRC, 32'h5555);
    fire(4'h5, 1'b1);
    no_start(20);
    fire(4'h5, 1'b0);
    wb(1'b1, OFS_CTRL, ctl(4'h3, 4'h0, 2'h0));
    wb(1'b1, OFS_PRIO, 32'h93);
    fire(4'h5, 1'b1);
    run_chk(2'h1, 4'h4);
    run_chk(2'h0, 4'h8);
    fire(4'h5, 1'b0);
    wb(1'b1, OFS_PRIO, 32'hE4);
    $display("test priority done");
  endtask : t_prio

  task automatic t_proc;
    int s0;
    wb(1'b1, OFS_CTRL, ctl(4'h5, 4'h0, 2'h0));
    wb(1'b1, OFS_TRIGSRC, 32'h0005);
    wb(1'b1, OFS_PROCTRIG, 32'h1);
    no_start(10);
    wb(1'b1, OFS_PROCTRIG, 32'h4);
    run_chk(2'h2, 4'h4);
    wb(1'b1, OFS_PROCTRIG, 32'h14);
    wb(1'b0, OFS_PROCTRIG, 32'h0);
    `CHK(q[3:0], 4'h4)
    no_start(10);
    sync_signal_in <= 1'b1;
    run_chk(2'h2, 4'h4);
    sync_signal_in <= 1'b0;
    s0 = sync_seen;
    wb(1'b1, OFS_PROCTRIG, 32'h24);
    run_chk(2'h2, 4'h4);
    `CHK(sync_seen - s0, 1)
    $display("test processor done");
  endtask : t_proc

  task automatic t_ovf;
    drain <= 1'b1;
    @(posedge clk);
    drain <= 1'b0;
    wb(1'b1, OFS_STATUS, 32'hF0);
    wb(1'b1, OFS_PROCTRIG, 32'h4);
    run_chk(2'h2, 4'h4);
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[7:4], 4'h0)
    wb(1'b1, OFS_PROCTRIG, 32'h4);
    run_chk(2'h2, 4'h4);
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[7:4], 4'h4)
    wb(1'b1, OFS_STATUS, 32'hF0);
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[7:4], 4'h0)
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_always;
    int cnt;
    wb(1'b1, OFS_TRIGSRC, 32'hF000);
    wb(1'b1, OFS_CTRL, ctl(4'h8, 4'h0, 2'h0));
    cnt = 0;
    repeat (80) begin
      @(posedge clk);
      if (conv_start_out === 1'b1) begin
        cnt++;
        `CHK(conv_seq_out, 2'h3)
      end
    end
    `CHK(cnt >= 4, 1'b1)
    wb(1'b1, OFS_CTRL, ctl(4'h0, 4'h0, 2'h0));
    no_start(3);
    $display("test always done");
  endtask : t_always

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ref();
    t_sources();
    t_phase();
    t_prio();
    t_proc();
    t_ovf();
    t_always();
    end_sim();
  end
endmodule : adc_sequence_trigger_control_tb_top
`default_nettype wire

// [testbench/conv_model.sv]
// Converter and sample buffer stand-in on the far side of the trigger block
`timescale 1ns/1ps
`default_nettype none
module conv_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic conv_start_out,
  input wire logic [1:0] conv_seq_out,
  input wire logic [7:0] run_len,
  input wire logic drain,
  output logic conv_done_in,
  output logic [3:0] fifo_empty_in
);
  logic [7:0] cnt_q;

  // Samples land only when a run ends; drain stands for software reading them all
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      conv_done_in <= 1'b0;
      fifo_empty_in <= 4'hF;
    end else begin
      conv_done_in <= (cnt_q == 8'h01);
      if (conv_start_out) begin
        cnt_q <= run_len;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      if (cnt_q == 8'h01) begin
        fifo_empty_in[conv_seq_out] <= 1'b0;
      end else if (drain) begin
        fifo_empty_in <= 4'hF;
      end
    end
  end
endmodule : conv_model
`default_nettype wire
